// ---- hdl/mdt_timer.sv ----
// Top of the multimode delay timer: mode sequencer, prescaler and counter
`timescale 1ns/1ps
module mdt_timer #(
    // Clock cycles per counting tick; shorten for simulation
    parameter int unsigned TICK_CYCLES = mdt_pkg::TICK_CYCLES
) (
    // Clock and power-up reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Pins, high means tied to the common terminal
    input  wire logic [1:0]  modeSel,
    input  wire logic [1:0]  rangeSel,
    input  wire logic        linkOk,
    input  wire logic        startIn,
    input  wire logic        resetIn,
    // Outputs
    output logic             loadOut,
    output logic             timingActive,
    output logic [15:0]      elapsedTicks
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int unsigned PIN_W = 7;                  // Pins carried by the synchroniser

    logic [PIN_W-1:0]        pinsSync;                  // Synchronised pin levels
    mdt_pkg::mdt_mode_e      mode;                      // Synchronised mode strap
    logic [1:0]              rangeSync;                 // Synchronised range select
    logic                    linkSync;                  // Timing element connected
    logic                    startSync;                 // Start level
    logic                    resetSync;                 // Reset level
    logic                    startPrev;                 // Start level one cycle ago
    logic                    startRise;                 // Start closure event

    logic [mdt_pkg::PRE_W-1:0] prescaler;               // Cycle counter toward one tick
    logic                    tick;                      // One-cycle enable per tick
    logic [15:0]             term;                      // Terminal count of the range
    logic                    atTerm;                    // Last tick of the interval

    mdt_pkg::mdt_state_e     state;                     // Sequencer state
    mdt_pkg::mdt_state_e     next_state;                // Next sequencer state
    logic                    next_load;                 // Next output level
    logic                    clearCount;                // Restart interval from zero
    logic                    countGo;                   // Counter may advance
    logic                    expire;                    // Interval completes this cycle

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    // Every pin is asynchronous to ref_clk; contacts may bounce, and the
    // two-flop stage only resynchronises, so each bounce still gives its own edge
    mdt_sync #(
        .WIDTH   (PIN_W)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .asyncIn ({modeSel, rangeSel, linkOk, startIn, resetIn}),
        .syncOut (pinsSync)
    );

    // Unpack the synchronised group
    assign mode      = mdt_pkg::mdt_mode_e'(pinsSync[6:5]);
    assign rangeSync = pinsSync[4:3];
    assign linkSync  = pinsSync[2];
    assign startSync = pinsSync[1];
    assign resetSync = pinsSync[0];

    // ****************************************************************
    // Start edge detection
    // ****************************************************************
    // Edge taken from the second flop only, never from the first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            startPrev <= 1'b0;
        end else begin
            startPrev <= startSync;
        end
    end

    // One event per rising edge of the synchronised start level
    assign startRise = startSync & ~startPrev;

    // ****************************************************************
    // Tick prescaler
    // ****************************************************************
    // Restarted with each interval so the first tick is a full period;
    // trades a free-running base for exact interval alignment
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescaler <= '0;
        end else if (clearCount) begin
            prescaler <= '0;
        end else if (countGo) begin
            // Held while paused so a partial tick carries into the next run
            prescaler <= tick ? '0 : prescaler + 1'b1;
        end
    end

    // Tick in the last cycle of each period
    assign tick = (prescaler == mdt_pkg::PRE_W'(TICK_CYCLES - 1));

    // ****************************************************************
    // Set time
    // ****************************************************************
    // Range pins may move at any time; the new terminal applies at once
    assign term   = mdt_pkg::mdt_term_count(rangeSync);
    // A greater-or-equal compare plus the saturating counter below keeps a range change
    // downward from running past the end forever
    assign atTerm = (elapsedTicks >= term - 16'h0001);
    assign expire = countGo & tick & atTerm;

    // ****************************************************************
    // Mode sequencer, next values
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_load  = loadOut;
        clearCount = 1'b0;
        countGo    = 1'b0;
        unique case (mode)
            // Time-limit and integrating operation from power-up
            mdt_pkg::MDT_ON_DELAY,
            mdt_pkg::MDT_INTEGRATE: begin
                if (resetSync) begin
                    // External reset clears timing and output
                    next_state = mdt_pkg::MDT_IDLE;
                    next_load  = 1'b0;
                    clearCount = 1'b1;
                end else begin
                    unique case (state)
                        // Reset open at power-up: start at once
                        mdt_pkg::MDT_IDLE: begin
                            next_state = mdt_pkg::MDT_RUN;
                            clearCount = 1'b1;
                        end
                        // Counting; integrating mode pauses on a broken link
                        mdt_pkg::MDT_RUN: begin
                            countGo = (mode == mdt_pkg::MDT_ON_DELAY) || linkSync;
                            if (expire) begin
                                next_state = mdt_pkg::MDT_DONE;
                                next_load  = 1'b1;
                            end
                        end
                        // Output held until reset or power-off
                        mdt_pkg::MDT_DONE: begin
                            next_load = 1'b1;
                        end
                        default: begin
                            next_state = mdt_pkg::MDT_IDLE;
                        end
                    endcase
                end
            end
            // One-shot pulse, non-retriggerable
            mdt_pkg::MDT_ONE_SHOT: begin
                unique case (state)
                    // Wait for a start closure
                    mdt_pkg::MDT_IDLE: begin
                        if (startRise) begin
                            next_state = mdt_pkg::MDT_RUN;
                            next_load  = 1'b1;
                            clearCount = 1'b1;
                        end
                    end
                    // Start edges are not looked at here
                    mdt_pkg::MDT_RUN: begin
                        countGo = 1'b1;
                        if (resetSync && !startSync) begin
                            // Reset with start open stops at once
                            next_state = mdt_pkg::MDT_IDLE;
                            next_load  = 1'b0;
                            countGo    = 1'b0;
                        end else if (expire) begin
                            next_state = mdt_pkg::MDT_IDLE;
                            next_load  = 1'b0;
                        end
                    end
                    // Left over from another mode strap
                    mdt_pkg::MDT_DONE: begin
                        next_state = mdt_pkg::MDT_IDLE;
                        next_load  = 1'b0;
                    end
                    default: begin
                        next_state = mdt_pkg::MDT_IDLE;
                    end
                endcase
            end
            // OFF-delay: output on start, timed off after reset opens
            mdt_pkg::MDT_OFF_DELAY: begin
                if (startRise) begin
                    // Output regardless of a reset held beforehand
                    next_state = mdt_pkg::MDT_RUN;
                    next_load  = 1'b1;
                    clearCount = 1'b1;
                end else begin
                    unique case (state)
                        mdt_pkg::MDT_IDLE: begin
                            next_load = 1'b0;
                        end
                        // Held at zero while reset closed, runs once it opens
                        mdt_pkg::MDT_RUN: begin
                            if (resetSync) begin
                                clearCount = 1'b1;
                            end else begin
                                countGo = 1'b1;
                                if (expire) begin
                                    next_state = mdt_pkg::MDT_IDLE;
                                    next_load  = 1'b0;
                                end
                            end
                        end
                        mdt_pkg::MDT_DONE: begin
                            next_state = mdt_pkg::MDT_IDLE;
                            next_load  = 1'b0;
                        end
                        default: begin
                            next_state = mdt_pkg::MDT_IDLE;
                        end
                    endcase
                end
            end
        endcase
    end

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= mdt_pkg::MDT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Elapsed tick counter
    // ****************************************************************
    // Kept across pauses so the intervals sum; saturates at one below the terminal count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsedTicks <= mdt_pkg::COUNT_RESET;
        end else if (clearCount) begin
            elapsedTicks <= mdt_pkg::COUNT_RESET;
        end else if (countGo && tick && !atTerm) begin
            elapsedTicks <= elapsedTicks + 16'h0001;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Load drive and busy flag straight from flip-flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            loadOut      <= mdt_pkg::LOAD_RESET;
            timingActive <= 1'b0;
        end else begin
            loadOut      <= next_load;
            timingActive <= (next_state == mdt_pkg::MDT_RUN);
        end
    end

endmodule : mdt_timer

// ---- hdl/mdt_pkg.sv ----
// Constants, types and helper function of the multimode delay timer
package mdt_pkg;

    // ****************************************************************
    // Clock and time base
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 40;          // ref_clk period, 25 MHz
    localparam int unsigned TICK_PERIOD_NS = 10_000_000;  // Base tick of the counting oscillator, 10 ms
    // Longest time: round down, never below one cycle
    localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_NS / CLK_PERIOD_NS) > 0 ?
                                             (TICK_PERIOD_NS / CLK_PERIOD_NS) : 1;
    localparam int unsigned PRE_W          = 18;          // Prescaler width, fits 250000
    localparam int unsigned SYNC_STAGES    = 2;           // Flip-flops in each pin synchroniser

    // ****************************************************************
    // Full-scale ranges in ticks (1 s, 10 s, 1 min, 10 min)
    // ****************************************************************
    localparam int unsigned CNT_W          = 16;
    localparam logic [15:0] RANGE0_TICKS   = 16'h0064;    // 1 s
    localparam logic [15:0] RANGE1_TICKS   = 16'h03E8;    // 10 s
    localparam logic [15:0] RANGE2_TICKS   = 16'h1770;    // 1 min
    localparam logic [15:0] RANGE3_TICKS   = 16'hEA60;    // 10 min

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] COUNT_RESET    = 16'h0000;    // Elapsed ticks after power-up
    localparam logic        LOAD_RESET     = 1'b0;        // Output off after power-up

    // ****************************************************************
    // Types
    // ****************************************************************
    // Operating mode strap, codes are the strap pin levels
    typedef enum logic [1:0] {
        MDT_ON_DELAY  = 2'b00,
        MDT_INTEGRATE = 2'b01,
        MDT_ONE_SHOT  = 2'b10,
        MDT_OFF_DELAY = 2'b11
    } mdt_mode_e;

    // Sequencer state
    typedef enum logic [1:0] {
        MDT_IDLE,
        MDT_RUN,
        MDT_DONE
    } mdt_state_e;

    // Terminal count of the selected range
    function automatic logic [15:0] mdt_term_count(input logic [1:0] rangeSel);
        logic [15:0] term;
        term = RANGE0_TICKS;
        unique case (rangeSel)
            2'b00: term = RANGE0_TICKS;
            2'b01: term = RANGE1_TICKS;
            2'b10: term = RANGE2_TICKS;
            2'b11: term = RANGE3_TICKS;
        endcase
        return term;
    endfunction : mdt_term_count

endpackage : mdt_pkg

// ---- hdl/mdt_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module mdt_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Pin side
    input  wire logic [WIDTH-1:0] asyncIn,
    // Clock side
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;  // Metastable stage, read only by stage two

    // ****************************************************************
    // Two flip-flops, open pins read as inactive at reset
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule : mdt_sync

// ---- test/mdt_contacts.sv ----
// Model of the contacts that drive the timer pins
`timescale 1ns/1ps
module mdt_contacts (
    // Clock and pace
    input  wire logic ref_clk,
    input  wire logic slow,       // Closure lags one cycle
    // Commands
    input  wire logic closeStart,
    input  wire logic closeReset,
    input  wire logic closeLink,
    // Pins, high is tied to common
    output logic      startIn,
    output logic      resetIn,
    output logic      linkOk
);
    // ****
    // Contacts
    // ****
    logic [2:0] lag = 3'b001;     // Commands one cycle back
    initial begin
        startIn = 1'b0;
        resetIn = 1'b0;
        linkOk  = 1'b1;
    end
    // Only tied or open levels exist
    always @(posedge ref_clk) begin
        lag <= {closeStart, closeReset, closeLink};
        {startIn, resetIn, linkOk} <= slow ? lag : {closeStart, closeReset, closeLink};
    end
endmodule : mdt_contacts

// ---- test/mdt_timer_asserts.sv ----
// Concurrent checks on the timer pins
`timescale 1ns/1ps
module mdt_timer_asserts #(
    parameter int unsigned TICK_CYCLES = mdt_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Pins
    input wire logic [1:0]  modeSel,
    input wire logic [1:0]  rangeSel,
    input wire logic        linkOk,
    input wire logic        startIn,
    input wire logic        resetIn,
    // Outputs
    input wire logic        loadOut,
    input wire logic        timingActive,
    input wire logic [15:0] elapsedTicks
);
    // ****
    // Checks
    // ****
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] termM1;          // Last count before expiry
    logic [15:0] prevE;           // Count one cycle back
    int          gap;             // Cycles since the count moved
    // Own copy of the range table
    always_comb begin
        case (rangeSel)
            2'b00:   termM1 = 16'h0063;
            2'b01:   termM1 = 16'h03E7;
            2'b10:   termM1 = 16'h176F;
            default: termM1 = 16'hEA5F;
        endcase
    end
    // Gap counter, catches a prescaler off by one
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevE <= 16'h0000;
            gap   <= 0;
        end else begin
            prevE <= elapsedTicks;
            gap   <= (elapsedTicks != prevE) ? 0 : gap + 1;
        end
    end
    sequence s_pulse_go;
        modeSel == 2'b10 && !timingActive && !loadOut && !resetIn && $rose(startIn) ##1 (startIn && !resetIn) [*3];
    endsequence
    sequence s_abort;
        modeSel == 2'b10 && timingActive && resetIn && !startIn ##1 (resetIn && !startIn) [*4];
    endsequence
    chk_reset_clear: assert property ((modeSel == 2'b00 && resetIn) [*7] |-> !loadOut && elapsedTicks == 16'h0000)
        else $error("reset did not clear");
    chk_pulse_start: assert property (s_pulse_go |-> ##[0:2] loadOut)
        else $error("pulse not started");
    chk_pulse_abort: assert property (s_abort |=> !loadOut && !timingActive)
        else $error("pulse not aborted");
    chk_pulse_ignore: assert property (modeSel == 2'b10 && timingActive && !resetIn && $rose(startIn)
        && elapsedTicks > 16'h0002 && elapsedTicks < termM1 - 16'h0008 |=> (elapsedTicks != 16'h0000) [*4])
        else $error("pulse retriggered");
    chk_hold_count: assert property ((modeSel == 2'b11 && resetIn) [*7] |-> elapsedTicks == 16'h0000)
        else $error("count ran under reset");
    chk_late_set: assert property (modeSel == 2'b11 && $rose(startIn) ##1 startIn [*3] |-> ##[0:2] loadOut)
        else $error("output not set");
    chk_pause_keep: assert property ((modeSel == 2'b01 && !linkOk && !resetIn) [*5] |=> $stable(elapsedTicks))
        else $error("count moved in pause");
    chk_rise_term: assert property ($rose(loadOut) && !modeSel[1] |-> $past(elapsedTicks) == termM1)
        else $error("output rose off terminal");
    chk_fall_term: assert property ((modeSel[1] && !resetIn) [*4] ##0 $fell(loadOut)
        |-> $past(elapsedTicks) == termM1)
        else $error("output fell off terminal");
    chk_tick_gap: assert property (elapsedTicks != prevE && elapsedTicks > 16'h0001 && modeSel != 2'b01
        |-> gap == TICK_CYCLES - 1)
        else $error("tick spacing wrong");
endmodule : mdt_timer_asserts
bind mdt_timer mdt_timer_asserts #(.TICK_CYCLES(TICK_CYCLES)) mdt_timer_asserts_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .modeSel(modeSel), .rangeSel(rangeSel), .linkOk(linkOk), .startIn(startIn),
    .resetIn(resetIn), .loadOut(loadOut), .timingActive(timingActive), .elapsedTicks(elapsedTicks));

// ---- test/tb.sv ----
// Self-checking bench of the multimode delay timer
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("Error at %0t got %h exp %h", $time, a, e); end end
module tb;
    // ****
    // Bench
    // ****
    typedef struct {logic [1:0] m; logic [1:0] r; logic st; logic imm; logic fin; int t;} mdt_row_s;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        rstCmd  = 1'b0;  // Power switch
    logic [1:0]  modeSel = 2'b00;
    logic [1:0]  rangeSel = 2'b00;
    logic [1:0]  modeCmd = 2'b00;
    logic [1:0]  rangeCmd = 2'b00;
    logic        closeStart = 1'b0;
    logic        closeReset = 1'b0;
    logic        closeLink = 1'b1;
    logic        slow = 1'b0;
    logic [15:0] held;            // Count kept over a pause
    wire logic   startIn, resetIn, linkOk, loadOut, timingActive;
    wire logic [15:0] elapsedTicks;
    int          n_fail = 0;
    int          check_count = 0;
    int          n;
    // One tick per clock keeps the longest range short
    mdt_row_s rows [7] = '{'{2'b00, 2'b00, 0, 0, 1, 100}, '{2'b00, 2'b01, 0, 0, 1, 1000},
        '{2'b00, 2'b10, 0, 0, 1, 6000}, '{2'b00, 2'b11, 0, 0, 1, 60000}, '{2'b01, 2'b00, 0, 0, 1, 100},
        '{2'b10, 2'b00, 1, 1, 0, 100}, '{2'b11, 2'b00, 1, 1, 0, 100}};
    always #20 ref_clk = ~ref_clk;
    // Straps and power change on the edge
    always @(posedge ref_clk) begin
        modeSel <= modeCmd;
        rangeSel <= rangeCmd;
        rst_n <= rstCmd;
    end
    mdt_contacts mdt_contacts_inst (.ref_clk(ref_clk), .slow(slow), .closeStart(closeStart),
        .closeReset(closeReset), .closeLink(closeLink), .startIn(startIn), .resetIn(resetIn), .linkOk(linkOk));
    mdt_timer #(.TICK_CYCLES(1)) mdt_timer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .modeSel(modeSel),
        .rangeSel(rangeSel), .linkOk(linkOk), .startIn(startIn), .resetIn(resetIn), .loadOut(loadOut),
        .timingActive(timingActive), .elapsedTicks(elapsedTicks));
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic test_done;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // Bounded wait for an output level
    task automatic wait_for(input logic v, input int lim, output int k);
        k = 0;
        while (loadOut !== v && k < lim) begin
            step(1);
            k++;
        end
        if (k >= lim) begin
            n_fail++;
            $display("Error at %0t got %h exp %h", $time, loadOut, v);
            test_done();
        end
    endtask : wait_for
    // Power cycle, then hold the reset contact so every mode, OFF-delay included, starts in MDT_IDLE at a zero count
    task automatic setup(input logic [1:0] m, input logic [1:0] r, input logic hold);
        modeCmd = m;
        rangeCmd = r;
        rstCmd = 1'b0;
        closeReset = 1'b1;
        step(4);
        rstCmd = 1'b1;
        step(8);
        closeReset = hold;
    endtask : setup
    function automatic logic inwin(input int k, input int t);
        return k >= t && k <= t + 12;
    endfunction : inwin
    initial begin
        step(2);
        `CHK({loadOut, timingActive, elapsedTicks}, 18'h0_0000)
        step(2);
        rstCmd = 1'b1;
        wait_for(1'b1, 150, n);
        `CHK(inwin(n, 100), 1'b1)
        closeReset = 1'b1;
        step(8);
        `CHK({loadOut, elapsedTicks}, 17'h0_0000)
        $display("power test done");
        foreach (rows[i]) begin
            setup(rows[i].m, rows[i].r, 1'b0);
            closeStart = rows[i].st;
            step(8);
            `CHK(loadOut, rows[i].imm)
            closeStart = 1'b0;
            wait_for(rows[i].fin, rows[i].t + 40, n);
            `CHK(inwin(n + 8, rows[i].t), 1'b1)
            $display("row %0d done", i);
        end
        // Integrating with a broken link
        setup(2'b01, 2'b00, 1'b0);
        step(40);
        closeLink = 1'b0;
        step(10);
        held = elapsedTicks;
        step(40);
        `CHK(elapsedTicks, held)
        closeLink = 1'b1;
        wait_for(1'b1, 200, n);
        `CHK(inwin(n + 90, 150), 1'b1)
        $display("pause test done");
        // One-shot: second start ignored, then an abort
        setup(2'b10, 2'b00, 1'b0);
        closeStart = 1'b1;
        step(4);
        closeStart = 1'b0;
        step(40);
        closeStart = 1'b1;
        step(4);
        closeStart = 1'b0;
        wait_for(1'b0, 150, n);
        `CHK(inwin(n + 48, 100), 1'b1)
        closeStart = 1'b1;
        step(4);
        closeStart = 1'b0;
        step(30);
        closeReset = 1'b1;
        step(6);
        `CHK({loadOut, timingActive}, 2'b00)
        $display("pulse test done");
        // OFF-delay under held reset, slow contacts
        setup(2'b11, 2'b00, 1'b1);
        slow = 1'b1;
        step(10);
        closeStart = 1'b1;
        step(8);
        `CHK(loadOut, 1'b1)
        step(150);
        `CHK({loadOut, elapsedTicks}, 17'h1_0000)
        closeReset = 1'b0;
        wait_for(1'b0, 150, n);
        `CHK(inwin(n, 100), 1'b1)
        closeStart = 1'b0;
        $display("off-delay test done");
        test_done();
    end
endmodule : tb
